// File: tape_read_and_mark_check.sv
`timescale 1ns/1ps
`include "tape_ctl_map.svh"
// Notes on behaviour
// - tp1 active read strobes first or second half
// - reverse loads complemented data, no reorder
// - assembled byte gives forward or reverse pulse
// - clear tp3, strobe tp1, transfer as count turns odd
// - no transfer pulse during checksum slot
// - xor all bytes; nonzero at stage 7 errors
// - gated internal clock drives gray divide by four
// - first gray bit edges drive time pulses
// - tape timing pulses blocked in track mode
// - mark window frozen in track mode
// - track mode: null, then active directly
// - track mode requests bytes, slot cannot suppress
// - mark track copies channel 0 data
// - track write enable needs three conditions
// - ring of six shifts tp2 except space or track mode
// - nonzero delay clear resets check enable
// - stage three preset ring, then enable checking
// - mark presence must match ring stage one
// - mark error sets info error on tp2
// - tp3 after sync resets check enable
// - eight stage data slot shift register
module tape_read_and_mark_check
    import tape_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    // classic wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // tape side
    input wire logic timing_pin_i,
    input wire logic [`HALF_W-1:0] read_amp_i,
    input wire mark_code_t window_code_i,
    input wire logic block_mark_stage_three_i,
    input wire logic track_switch_off_i,
    input wire logic [`BYTE_W-1:0] write_byte_i,
    // channel controller side
    output logic [`BYTE_W-1:0] read_byte_o,
    output logic xfer_fwd_o,
    output logic xfer_rev_o,
    output logic byte_request_o,
    // track writing
    output logic timing_track_o,
    output logic mark_track_o,
    output logic track_format_write_enable_o,
    output logic track_head_relay_o,
    output logic window_shift_o
);
    // ------------------------------------------------------------
    // internal state
    // ------------------------------------------------------------
    pulse_if tp_bus (); // time pulse bundle
    logic [5:0] ctrl_reg; // software control word
    logic read_mode; // read selected
    logic reverse; // tape moving reverse
    logic track_format_write_cmd; // track write mode level
    logic data_write_enable; // no write lock
    logic command_clear_pulse; // start pulse from software
    logic delay_nonzero; // command given with delay
    xfer_state_t state_reg; // null, request, active
    logic [`BYTE_W-1:0] assembly_buffer; // byte being built
    logic [`BYTE_W-1:0] longitudinal_buffer; // running xor
    logic count_reg; // 1 = odd, 0 = even
    logic [`SLOT_W-1:0] slot_reg; // data slot shift register
    logic checksum_slot; // stage 1 or 6 holds the one
    logic xfer_go; // byte completes this tp2
    logic information_error_flag; // sticky read error
    logic mark_error_level; // from checker
    logic mark_check_enable; // from checker
    logic [`HALF_W-1:0] half_in; // direct or complement
    logic wb_hit; // new bus request
    logic clr_err; // software clear of error

    assign read_mode = ctrl_reg[`CTRL_READ_BIT];
    assign reverse = ctrl_reg[`CTRL_REV_BIT];
    assign track_format_write_cmd = ctrl_reg[`CTRL_TRACK_WR_BIT];
    assign data_write_enable = ctrl_reg[`CTRL_DATA_WREN_BIT];
    assign delay_nonzero = ctrl_reg[`CTRL_DELAY_BIT];

    // ------------------------------------------------------------
    // helper modules
    // ------------------------------------------------------------
    pulse_chain u_chain (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .track_mode_i(track_format_write_cmd),
        .timing_pin_i(timing_pin_i),
        .tp(tp_bus.src)
    );

    mark_check u_check (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tp(tp_bus.dst),
        .command_clear_pulse_i(command_clear_pulse),
        // the new command's delay bit, not the word it replaces
        .delay_nonzero_i(wb_dat_i[`CTRL_DELAY_BIT]),
        .track_mode_i(track_format_write_cmd),
        .window_i(window_code_i),
        .block_mark_stage_three_i(block_mark_stage_three_i),
        .mark_error_level_o(mark_error_level),
        .mark_check_enable_o(mark_check_enable)
    );

    // ------------------------------------------------------------
    // wishbone slave, ack one cycle after the strobe
    // ------------------------------------------------------------
    assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign command_clear_pulse = wb_hit && wb_we_i && wb_sel_i[0] &&
        (wb_adr_i == `CTRL_OFS) && wb_dat_i[`CTRL_START_BIT];
    assign clr_err = wb_hit && wb_we_i && wb_sel_i[0] &&
        (wb_adr_i == `CLRERR_OFS) && wb_dat_i[`STAT_INFO_ERR_BIT];

    // control word, start bit is a pulse and never stored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= `CTRL_RESET;
        end else if (wb_hit && wb_we_i && wb_sel_i[0] &&
                     wb_adr_i == `CTRL_OFS) begin
            ctrl_reg <= wb_dat_i[5:0] & 6'h2f;
        end
    end

    // ack and read mux; unmapped reads return zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_hit;
            wb_dat_o <= 32'h0000_0000;
            if (wb_hit && !wb_we_i) begin
                case (wb_adr_i)
                    `CTRL_OFS: wb_dat_o <= {26'h0, ctrl_reg};
                    `STATUS_OFS: wb_dat_o <= {27'h0,
                        track_format_write_enable_o,
                        state_reg == st_active, mark_check_enable,
                        mark_error_level, information_error_flag};
                    `RDATA_OFS: wb_dat_o <= {26'h0, read_byte_o};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // transfer state
    // ------------------------------------------------------------
    // start enters null; track mode goes active skipping request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= st_null;
        end else if (command_clear_pulse) begin
            state_reg <= st_null;
        end else begin
            case (state_reg)
                st_null: begin
                    if (delay_nonzero && tp_bus.tp2)
                        state_reg <= track_format_write_cmd ?
                            st_active : st_request;
                end
                st_request: begin
                    if (track_format_write_cmd)
                        state_reg <= st_null;
                    else if (slot_reg[1] && tp_bus.tp2)
                        state_reg <= st_active;
                end
                st_active: state_reg <= st_active;
                default: state_reg <= st_null;
            endcase
        end
    end

    // ------------------------------------------------------------
    // data slot register
    // ------------------------------------------------------------
    // shifts on tp2 for data codes; frozen with the window
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            slot_reg <= 8'h00;
        end else if (tp_bus.tp2 && !track_format_write_cmd &&
                     (window_code_i == mk_data_sync ||
                      window_code_i == mk_data_end)) begin
            slot_reg <= {slot_reg[`SLOT_W-2:0],
                window_code_i == mk_data_sync};
        end
    end
    assign checksum_slot = slot_reg[1] || slot_reg[6];

    // ------------------------------------------------------------
    // read datapath
    // ------------------------------------------------------------
    // complement only; halves swapped by the far side
    assign half_in = reverse ? ~read_amp_i : read_amp_i;
    // transfer on tp2 when count turns odd, not in a checksum
    assign xfer_go = tp_bus.tp2 && !count_reg && read_mode &&
        state_reg == st_active && !checksum_slot;

    // byte assembly: clear tp3, strobes on tp1
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            assembly_buffer <= 6'h00;
            count_reg <= 1'b1;
        end else if (state_reg != st_active) begin
            count_reg <= 1'b1;
        end else begin
            // clear only after a handover, else the first half is lost
            if (tp_bus.tp3 && count_reg)
                assembly_buffer <= 6'h00;
            if (tp_bus.tp1 && read_mode) begin
                if (count_reg)
                    assembly_buffer[5:3] <= half_in;
                else
                    assembly_buffer[2:0] <= half_in;
            end
            if (tp_bus.tp2)
                count_reg <= ~count_reg;
        end
    end

    // hand byte over with direction pulse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            read_byte_o <= 6'h00;
            xfer_fwd_o <= 1'b0;
            xfer_rev_o <= 1'b0;
        end else begin
            xfer_fwd_o <= xfer_go && !reverse;
            xfer_rev_o <= xfer_go && reverse;
            if (xfer_go)
                read_byte_o <= assembly_buffer;
        end
    end

    // checksum accumulates every byte, checksum slots too
    always_ff @(posedge clk_i) begin
        if (rst_i || (state_reg != st_active && command_clear_pulse)) begin
            longitudinal_buffer <= 6'h00;
        end else if (tp_bus.tp2 && !count_reg && read_mode &&
                     state_reg == st_active) begin
            longitudinal_buffer <= longitudinal_buffer ^
                assembly_buffer;
        end
    end

    // sticky error: set wins over software clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            information_error_flag <= 1'b0;
        end else if ((read_mode && slot_reg[`SLOT_CHECK_STAGE] &&
                      tp_bus.tp2 && longitudinal_buffer != 6'h00) ||
                     (tp_bus.tp2 && mark_error_level)) begin
            information_error_flag <= 1'b1;
        end else if (clr_err) begin
            information_error_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // track writing outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            byte_request_o <= 1'b0;
            timing_track_o <= 1'b0;
            mark_track_o <= 1'b0;
            track_format_write_enable_o <= 1'b0;
            track_head_relay_o <= 1'b0;
            window_shift_o <= 1'b0;
        end else begin
            // slot register cannot veto requests in track mode
            byte_request_o <= tp_bus.tp4 && count_reg && !read_mode &&
                state_reg == st_active &&
                (track_format_write_cmd || !checksum_slot);
            if (tp_bus.tp1 || tp_bus.tp3)
                timing_track_o <= ~timing_track_o;
            mark_track_o <= track_format_write_cmd &&
                write_byte_i[0];
            track_format_write_enable_o <= data_write_enable &&
                !track_switch_off_i && track_format_write_cmd;
            track_head_relay_o <= !track_switch_off_i;
            window_shift_o <= tp_bus.tp1 &&
                !track_format_write_cmd;
        end
    end
endmodule : tape_read_and_mark_check

// File: tape_ctl_map.svh
`ifndef TAPE_CTL_MAP_SVH
`define TAPE_CTL_MAP_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses, one word each)
// ----------------------------------------------------------------
`define CTRL_OFS 8'h00
`define STATUS_OFS 8'h04
`define RDATA_OFS 8'h08
`define CLRERR_OFS 8'h0c

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define CTRL_READ_BIT 0
`define CTRL_REV_BIT 1
`define CTRL_TRACK_WR_BIT 2
`define CTRL_DATA_WREN_BIT 3
`define CTRL_START_BIT 4
`define CTRL_DELAY_BIT 5
`define CTRL_RESET 6'h00

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define STAT_INFO_ERR_BIT 0
`define STAT_MARK_ERR_BIT 1
`define STAT_CHECK_EN_BIT 2
`define STAT_ACTIVE_BIT 3
`define STAT_TRACK_EN_BIT 4

// ----------------------------------------------------------------
// widths, presets and timing
// ----------------------------------------------------------------
`define BYTE_W 6
`define HALF_W 3
`define RING_W 6
`define SLOT_W 8
`define RING_PRESET 6'h20
`define SLOT_CHECK_STAGE 7
`define CLK_HZ 20000000
`define TRACK_CLK_NS 2500
`define TRACK_CLK_DIV ((`TRACK_CLK_NS * (`CLK_HZ / 1000000)) / 1000)

`endif

// File: tape_pkg.sv
package tape_pkg;
    // link state of the data transfer engine
    typedef enum logic [1:0] {
        st_null,
        st_request,
        st_active
    } xfer_state_t;
    // mark track window codes, decoded upstream
    typedef enum logic [2:0] {
        mk_none,
        mk_bm_space,
        mk_bm_sync,
        mk_data_sync,
        mk_data_end,
        mk_other
    } mark_code_t;
endpackage : tape_pkg

// File: pulse_if.sv
`timescale 1ns/1ps
// time pulse bundle between the pulse chain and the main logic
interface pulse_if;
    logic tp1;
    logic tp2;
    logic tp3;
    logic tp4;
    modport src (output tp1, output tp2, output tp3, output tp4);
    modport dst (input tp1, input tp2, input tp3, input tp4);
endinterface : pulse_if

// File: pulse_chain.sv
`timescale 1ns/1ps
`include "tape_ctl_map.svh"
module pulse_chain
    import tape_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic track_mode_i,
    input wire logic timing_pin_i,
    pulse_if.src tp
);
    // --------------------------------------------------------
    // synchroniser and internal track clock
    // --------------------------------------------------------
    logic [2:0] sync_reg; // pin synchroniser, stage 0 unread here
    logic tape_edge; // agreed change of timing track
    logic last_reg; // last agreed level
    logic [15:0] div_reg; // internal clock divider
    logic [1:0] gray_reg; // 00,01,11,10 divider
    logic gray_b1_d_reg; // previous first bit
    logic kick; // one step of the chain
    logic [1:0] phase_reg; // which pulse comes next

    // three flops; change counts when stages 1 and 2 agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_reg <= 3'h0;
            last_reg <= 1'b0;
        end else begin
            sync_reg <= {sync_reg[1:0], timing_pin_i};
            if (sync_reg[1] == sync_reg[2])
                last_reg <= sync_reg[2];
        end
    end
    assign tape_edge = (sync_reg[1] == sync_reg[2]) &&
                       (sync_reg[2] != last_reg);

    // internal clock runs only with the mode level
    always_ff @(posedge clk_i) begin
        if (rst_i || !track_mode_i) begin
            div_reg <= 16'h0000;
            gray_reg <= 2'h0;
        end else if (div_reg == 16'(`TRACK_CLK_DIV - 1)) begin
            div_reg <= 16'h0000;
            gray_reg <= {gray_reg[0], ~gray_reg[1]};
        end else begin
            div_reg <= div_reg + 16'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i)
            gray_b1_d_reg <= 1'b0;
        else
            gray_b1_d_reg <= gray_reg[1];
    end

    // tape pulses blocked in track mode, substitute used instead
    assign kick = track_mode_i ? (gray_reg[1] != gray_b1_d_reg)
                               : tape_edge;

    // four repeating pulses, one cycle wide
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_reg <= 2'h0;
            tp.tp1 <= 1'b0;
            tp.tp2 <= 1'b0;
            tp.tp3 <= 1'b0;
            tp.tp4 <= 1'b0;
        end else begin
            tp.tp1 <= kick && (phase_reg == 2'h0);
            tp.tp2 <= kick && (phase_reg == 2'h1);
            tp.tp3 <= kick && (phase_reg == 2'h2);
            tp.tp4 <= kick && (phase_reg == 2'h3);
            if (kick)
                phase_reg <= phase_reg + 2'h1;
        end
    end
endmodule : pulse_chain

// File: mark_check.sv
`timescale 1ns/1ps
`include "tape_ctl_map.svh"
module mark_check
    import tape_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    pulse_if.dst tp,
    input wire logic command_clear_pulse_i,
    input wire logic delay_nonzero_i,
    input wire logic track_mode_i,
    input wire mark_code_t window_i,
    input wire logic block_mark_stage_three_i,
    output logic mark_error_level_o,
    output logic mark_check_enable_o
);
    // --------------------------------------------------------
    // ring counter and check enable
    // --------------------------------------------------------
    logic [`RING_W-1:0] mark_ring_counter; // single travelling one
    logic legit_mark_level; // any valid code in window
    logic space_in_win; // block mark space code
    logic stage3_d_reg; // stage three delayed a pulse three
    logic sync_seen_reg; // block mark sync seen

    assign space_in_win = (window_i == mk_bm_space);
    assign legit_mark_level = (window_i != mk_none);

    // ring shift on pulse two, preset on pulse three
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mark_ring_counter <= `RING_PRESET;
        end else if (tp.tp3 && block_mark_stage_three_i &&
                     !stage3_d_reg && space_in_win) begin
            mark_ring_counter <= `RING_PRESET;
        end else if (tp.tp2 && !space_in_win && !track_mode_i) begin
            mark_ring_counter <= {mark_ring_counter[0],
                mark_ring_counter[`RING_W-1:1]};
        end
    end

    // edge memory of stage three, sampled on pulse three; sync caught on any cycle, cleared on pulse three
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stage3_d_reg <= 1'b0;
            sync_seen_reg <= 1'b0;
        end else begin
            if (tp.tp3)
                stage3_d_reg <= block_mark_stage_three_i;
            if (window_i == mk_bm_sync)
                sync_seen_reg <= 1'b1;
            else if (tp.tp3)
                sync_seen_reg <= 1'b0;
        end
    end

    // check enable: clear wins only through explicit order here
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mark_check_enable_o <= 1'b0;
        end else if (command_clear_pulse_i && delay_nonzero_i) begin
            mark_check_enable_o <= 1'b0;
        end else if (tp.tp3 && sync_seen_reg) begin
            mark_check_enable_o <= 1'b0;
        end else if (tp.tp3 && block_mark_stage_three_i &&
                     stage3_d_reg && !space_in_win) begin
            mark_check_enable_o <= 1'b1;
        end
    end

    // error when mark presence disagrees with ring stage one
    always_ff @(posedge clk_i) begin
        if (rst_i)
            mark_error_level_o <= 1'b0;
        else
            mark_error_level_o <= mark_check_enable_o && !track_mode_i &&
                (legit_mark_level != mark_ring_counter[`RING_W-1]);
    end
endmodule : mark_check

// File: tape_chan_model.sv
`timescale 1ns/1ps
// channel controller stand-in on the far side of the byte link
module tape_chan_model (
    input wire logic clk_i,
    input wire logic xfer_fwd_i,
    input wire logic xfer_rev_i,
    input wire logic [5:0] byte_i,
    input wire logic byte_request_i,
    output logic [5:0] write_byte_o
);
    logic [5:0] got[$]; // accumulator contents, one per byte
    initial write_byte_o = 6'h00;
    // take read bytes, hand out a fresh write byte on each request
    always @(posedge clk_i) begin
        if (xfer_fwd_i) got.push_back(byte_i);
        // halves swapped so reverse bytes come out the right way round
        if (xfer_rev_i) got.push_back({byte_i[2:0], byte_i[5:3]});
        if (byte_request_i) write_byte_o <= 6'($urandom);
    end
endmodule : tape_chan_model

// File: tape_read_and_mark_check_chk.sv
`timescale 1ns/1ps
module tape_mark_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic track_switch_off_i,
    input wire logic [5:0] write_byte_i,
    input wire logic xfer_fwd_o,
    input wire logic xfer_rev_o,
    input wire logic mark_track_o,
    input wire logic track_format_write_enable_o,
    input wire logic track_head_relay_o,
    input wire logic window_shift_o
);
    // ------------------------------------------------------------
    // port relations, all in the one clock domain
    // ------------------------------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // a bus request not yet answered
    sequence req_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    ack_next_a: assert property (req_s |=> wb_ack_o) else $error("no ack");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("data outside ack");
    xfer_excl_a: assert property (!(xfer_fwd_o && xfer_rev_o))
        else $error("both directions");
    xfer_pulse_a: assert property ((xfer_fwd_o || xfer_rev_o) |=>
        !(xfer_fwd_o || xfer_rev_o)) else $error("long transfer");
    mark_copy_a: assert property (mark_track_o |->
        $past(write_byte_i[0])) else $error("mark not channel 0");
    relay_follow_a: assert property (!$past(rst_i) |->
        track_head_relay_o == !$past(track_switch_off_i))
        else $error("relay wrong");
    track_gate_a: assert property (track_format_write_enable_o |->
        !$past(track_switch_off_i)) else $error("enable with switch off");
    frozen_win_a: assert property (window_shift_o |->
        !mark_track_o) else $error("window shifts in track mode");
endmodule : tape_mark_chk
bind tape_read_and_mark_check tape_mark_chk tape_mark_chk_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .track_switch_off_i(track_switch_off_i), .write_byte_i(write_byte_i),
    .xfer_fwd_o(xfer_fwd_o), .xfer_rev_o(xfer_rev_o),
    .mark_track_o(mark_track_o),
    .track_format_write_enable_o(track_format_write_enable_o),
    .track_head_relay_o(track_head_relay_o),
    .window_shift_o(window_shift_o));

// File: tape_read_and_mark_check_tb.sv
`timescale 1ns/1ps
module tape_read_and_mark_check_tb;
    import tape_pkg::*;
    // ------------------------------------------------------------
    // bench signals, model state, instances
    // ------------------------------------------------------------
    logic clk_i, rst_i, cyc, stb, we, ack, pin, b3, swoff, fwd, rev;
    logic req, ttrk, mtrk, ten, relay, wsh, last_t;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dw, dr, rd;
    logic [2:0] amp;
    logic [5:0] wbyte, rbyte, exp_b;
    mark_code_t win;
    int err_total, n_compared, edges, dir, nx, i, r, nreq, ntog, v;
    int hist[$]; // halves shown at each tp1, oldest first
    tape_read_and_mark_check tape_read_and_mark_check_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw),
        .wb_dat_o(dr), .wb_ack_o(ack), .timing_pin_i(pin),
        .read_amp_i(amp), .window_code_i(win),
        .block_mark_stage_three_i(b3), .track_switch_off_i(swoff),
        .write_byte_i(wbyte), .read_byte_o(rbyte), .xfer_fwd_o(fwd),
        .xfer_rev_o(rev), .byte_request_o(req), .timing_track_o(ttrk),
        .mark_track_o(mtrk), .track_format_write_enable_o(ten),
        .track_head_relay_o(relay), .window_shift_o(wsh));
    tape_chan_model tape_chan_model_i (.clk_i(clk_i), .xfer_fwd_i(fwd),
        .xfer_rev_i(rev), .byte_i(rbyte), .byte_request_i(req),
        .write_byte_o(wbyte));
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask : check
    task automatic end_of_test;
        $display("compares %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test
    // one classic cycle; waits for ack, bounded
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        @(posedge clk_i);
        {cyc, stb, we, adr, dw, sel} <= {1'b1, 1'b1, w, a, d, 4'h1};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            err_total++;
            end_of_test();
        end
        rd = dr;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    // timing track edges; tp1 is every fourth edge from reset
    task automatic step(input int n);
        repeat (n) begin
            if (edges % 4 == 0) begin
                v = $urandom_range(7);
                amp <= v[2:0];
                hist.push_back(v);
            end
            b3 <= 1'($urandom);
            pin <= ~pin;
            edges++;
            repeat (8) @(posedge clk_i);
        end
    endtask : step
    // byte model: last two strobed halves, complemented in reverse
    always @(posedge clk_i) begin
        if ((fwd || rev) && hist.size() > 1) begin
            exp_b = {hist[$-1][2:0], hist[$][2:0]};
            if (dir != 0) exp_b = ~exp_b;
            nx++;
            check({31'h0, rev}, dir);
            check({26'h0, rbyte}, {26'h0, exp_b});
        end
    end
    initial begin
        void'($urandom(13449));
        {cyc, stb, we, pin, b3, swoff, amp, adr, dw, sel} = '0;
        win = mk_none;
        rst_i = 1'b1;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        // reset values of control and status, unmapped place
        wb(0, 8'h00, 0);
        check(rd, 0);
        wb(0, 8'h04, 0);
        check(rd, 0);
        wb(0, 8'h10, 0);
        check(rd, 0);
        $display("register test done");
        // read forward then reverse
        for (dir = 0; dir < 2; dir++) begin
            nx = 0;
            wb(1, 8'h00, 32'h31 | (dir << 1));
            wb(0, 8'h00, 0);
            check(rd, 32'h21 | (dir << 1)); // start bit reads back 0
            for (r = 0; r < 14; r++) begin
                win <= (r == 0) ? mk_data_sync :
                       (r == 5) ? mk_none : mk_data_end;
                step(4);
            end
            check(nx, 4);
            check(tape_chan_model_i.got[$], dir ?
                {exp_b[2:0], exp_b[5:3]} : exp_b);
            wb(0, 8'h08, 0);
            check(rd, {26'h0, exp_b});
            $display("read test %0d done", dir);
        end
        // track write mode on its own clock
        b3 <= 1'b0;
        wb(1, 8'h00, 32'h3c);
        wb(1, 8'h0c, 32'h1);
        for (i = 0; i < 900 && req !== 1'b1; i++) @(posedge clk_i);
        if (req !== 1'b1) begin
            err_total++;
            end_of_test();
        end
        wb(0, 8'h04, 0);
        check(rd[4:0], 5'h18);
        {nreq, ntog, last_t} = {32'h0, 32'h0, ttrk};
        for (i = 0; i < 1600; i++) begin
            if (i % 8 == 0) pin <= ~pin; // tape pulses must stay blocked
            @(posedge clk_i);
            nreq += int'(req);
            ntog += int'(ttrk != last_t);
            last_t = ttrk;
        end
        check(nreq, 2);
        check(ntog, 8);
        swoff <= 1'b1;
        wb(0, 8'h04, 0);
        check(rd[4], 1'b0);
        $display("track test done");
        end_of_test();
    end
endmodule : tape_read_and_mark_check_tb
